// *** rtl/sysreg_pkg.sv ***
package sysreg_pkg;
  // field positions of the system control / rom window register
  localparam int rom_lsb = 0;
  localparam int rom_msb = 7;
  localparam int ctl_lsb = 8;
  localparam int ctl_msb = 25;
  localparam int ioh_lsb = 8;
  localparam int ioh_msb = 16;
  localparam int csz_lsb = 17;
  localparam int csz_msb = 18;
  localparam int slip_lsb = 19;
  localparam int slip_msb = 20;
  localparam int wrap_bit = 21;
  localparam int mty_lsb = 22;
  localparam int mty_msb = 24;
  localparam int coff_bit = 25;
  localparam int out_lsb = 26;
  localparam int out_msb = 29;
  localparam int pd_lsb = 26;
  localparam int pd_msb = 27;
  localparam int jmp_lsb = 28;
  localparam int jmp_msb = 31;
  // processor address bits feeding the io address, and the bit that picks the first half of a wrap fill
  localparam int adr_lo = 9;
  localparam int adr_hi = 29;
  localparam int adr_rom_hi = 28;
  localparam int adr_half_bit = 4;
  // control field reset value
  localparam logic [17:0] ctl_reset = 18'h00000;
  localparam logic [3:0] out_reset = 4'h0;
  // cache size codes
  localparam logic [1:0] csz_128k = 2'h0;
  localparam logic [1:0] csz_256k = 2'h1;
  localparam logic [1:0] csz_512k = 2'h2;
  // timing: one slip cycle is one board state-machine cycle
  localparam real slip_ns = 39.6;
  localparam real clk_ns = 20.0;
  localparam int slip_clks = (int'($ceil(slip_ns / clk_ns)) < 1) ? 1 : int'($ceil(slip_ns / clk_ns));

  typedef struct packed {
    logic cache_off;
    logic [2:0] mem_type;
    logic wrap_read;
    logic [1:0] cas_slip;
    logic [1:0] cache_size;
    logic [8:0] io_addr_high;
  } ctl_s;
endpackage

// *** rtl/sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input wire logic sys_clk,
  input wire logic resetn,
  output logic rst_n
);
  logic stage;
  // two-stage release keeps reset deassertion clean
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      stage <= 1'b1;
      rst_n <= stage;
    end
  end
endmodule
`default_nettype wire

// *** rtl/board_system_register_rom_window.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - claim zone access, keep isa chipset off
// - write stores data bits 29:8 only
// - write bits 29:26 to analyzer outputs
// - read low byte from rom window
// - read bits 25:8 return control fields
// - read bits 31:26 are config inputs
// - bits 16:8 form io address 31:23
// - cache size code selects 128/256/512 kb
// - slip adds 0..3 cycles per read cas
// - wrap bit picks first half of fill
// - cache off disables probes, dma to dram
// - jumpers read on bits 31:28, low fitted
// - config one separates 16 mb modules
// - rom top address high or io bit 21
// - one rom socket enabled, zero default
module board_system_register_rom_window #(
  parameter int slip_max = 3
) (
  input wire logic sys_clk,
  input wire logic resetn,
  // io state machine access
  input wire logic zone_select,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [33:0] cpu_addr,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data,
  output logic zone_claim_n,
  // debug rom sockets
  output logic [31:0] io_addr,
  input wire logic [7:0] io_data,
  input wire logic rom_size_1mb,
  input wire logic rom_select_one,
  output logic rom_top_addr,
  output logic rom_socket_zero_en_n,
  output logic rom_socket_one_en_n,
  // board configuration
  input wire logic [1:0] simm_presence_detect,
  input wire logic [3:0] sys_config_n,
  output logic [3:0] analyzer_out,
  // memory controller interface
  input wire logic fill_start,
  input wire logic fill_second_cas,
  output logic [1:0] cas_slip_left,
  output logic slip_busy,
  output logic first_half_high,
  output logic cache_probe_en,
  output logic dma_to_dram,
  output logic [1:0] cache_size,
  output logic [2:0] mem_type,
  output logic simm_16mb
);
  logic rst_n;
  sysreg_pkg::ctl_s ctl;
  logic [3:0] out_q;
  logic [7:0] slip_cnt;
  logic [1:0] slip_rem;
  logic [31:0] read_word;

  sync2 reset_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rst_n(rst_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode and rom window
  // claim follows the zone decode combinationally so the chipset sees it in time
  assign zone_claim_n = !(zone_select && (reg_read || reg_write));
  // upper bits come from the register, lower from the processor address
  assign io_addr = {ctl.io_addr_high, cpu_addr[sysreg_pkg::adr_hi:sysreg_pkg::adr_lo], 2'h0};
  // 512 kb parts want the top pin pulled high
  assign rom_top_addr = rom_size_1mb ? io_addr[21] : 1'b1;
  // both enables are never low together, avoiding drive contention
  assign rom_socket_zero_en_n = !(zone_select && reg_read && !rom_select_one);
  assign rom_socket_one_en_n = !(zone_select && reg_read && rom_select_one);

  ////////////////////////////////////////////////////////////////////////
  // control fields
  // low byte of write data is dropped on purpose
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= sysreg_pkg::ctl_reset;
    end else if (zone_select && reg_write) begin
      ctl <= wr_data[sysreg_pkg::ctl_msb:sysreg_pkg::ctl_lsb];
    end
  end

  // analyzer outputs are write only, never fed back to reads
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= sysreg_pkg::out_reset;
    end else if (zone_select && reg_write) begin
      out_q <= wr_data[sysreg_pkg::out_msb:sysreg_pkg::out_lsb];
    end
  end
  assign analyzer_out = out_q;

  ////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    read_word = 32'h00000000;
    read_word[sysreg_pkg::rom_msb:sysreg_pkg::rom_lsb] = io_data;
    read_word[sysreg_pkg::ctl_msb:sysreg_pkg::ctl_lsb] = ctl;
    read_word[sysreg_pkg::pd_msb:sysreg_pkg::pd_lsb] = simm_presence_detect;
    read_word[sysreg_pkg::jmp_msb:sysreg_pkg::jmp_lsb] = sys_config_n;
  end

  // read data is registered one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h00000000;
    end else if (zone_select && reg_read) begin
      rd_data <= read_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory controller controls
  assign cache_size = ctl.cache_size;
  assign mem_type = ctl.mem_type;
  // fitted jumper pulls the line low and means 16 mb modules
  assign simm_16mb = !sys_config_n[1];
  assign cache_probe_en = !ctl.cache_off;
  assign dma_to_dram = ctl.cache_off;
  // wrap off always returns the low half first
  assign first_half_high = ctl.wrap_read && cpu_addr[sysreg_pkg::adr_half_bit];

  // slip counter: each slip is a board cycle expressed in sys_clk ticks
  // only read fills load it, so writes are never slowed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slip_rem <= 2'h0;
      slip_cnt <= 8'h00;
    end else if (fill_start || fill_second_cas) begin
      slip_rem <= ctl.cas_slip;
      slip_cnt <= 8'(sysreg_pkg::slip_clks - 1);
    end else if (slip_rem != 2'h0) begin
      if (slip_cnt == 8'h00) begin
        slip_rem <= slip_rem - 2'h1;
        slip_cnt <= 8'(sysreg_pkg::slip_clks - 1);
      end else begin
        slip_cnt <= slip_cnt - 8'h01;
      end
    end
  end
  assign cas_slip_left = slip_rem;
  assign slip_busy = (slip_rem != 2'h0);

  ////////////////////////////////////////////////////////////////////////
  // checks
  // zone claim: low exactly while an access of our zone stands, so the chipset never answers twice
  a_claim_on_access: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zone_select && (reg_read || reg_write)) |-> !zone_claim_n) else $error("claim missing");
  a_claim_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(zone_select && (reg_read || reg_write)) |-> zone_claim_n) else $error("claim outside zone access");

  // write side: control fields and analyzer outputs take the strobed word, and the analyzer outputs then hold
  a_write_stores_ctl: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zone_select && reg_write) |=> ctl == $past(wr_data[25:8])) else $error("ctl not written");
  a_analyzer_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zone_select && reg_write) |=> analyzer_out == $past(wr_data[29:26])) else $error("analyzer bad");
  a_analyzer_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(zone_select && reg_write) |=> $stable(analyzer_out)) else $error("analyzer changed without write");
  a_cache_size_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zone_select && reg_write) |=> cache_size == $past(wr_data[18:17])) else $error("cache size not written");
  a_mem_type_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zone_select && reg_write) |=> mem_type == $past(wr_data[24:22])) else $error("memory type not written");

  // read side: one registered word, held until the next read strobe
  a_read_rom_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zone_select && reg_read) |=> rd_data[7:0] == $past(io_data)) else $error("rom byte bad");
  a_read_ctl_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zone_select && reg_read) |=> rd_data[25:8] == $past(ctl)) else $error("ctl readback bad");
  a_read_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(zone_select && reg_read) |=> $stable(rd_data)) else $error("read data changed without read");
  a_read_config: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zone_select && reg_read) |=> rd_data[31:26] == $past({sys_config_n, simm_presence_detect}))
    else $error("config readback bad");
  a_read_jumpers: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zone_select && reg_read) |=> rd_data[31:28] == $past(sys_config_n)) else $error("jumper readback bad");

  // io address and rom sockets
  a_io_high_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    io_addr[31:23] == ctl[8:0]) else $error("io high bits bad");
  a_io_low_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    io_addr[22:2] == cpu_addr[29:9]) else $error("io low bits bad");
  a_rom_top_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rom_size_1mb |-> rom_top_addr) else $error("rom top pin not high");
  a_rom_top_1mb: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rom_size_1mb |-> rom_top_addr == io_addr[21]) else $error("rom top pin not from io address");
  a_one_socket: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(!rom_socket_zero_en_n && !rom_socket_one_en_n)) else $error("two sockets enabled");
  a_socket_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(zone_select && reg_read) |-> (rom_socket_zero_en_n && rom_socket_one_en_n))
    else $error("socket enabled outside read");

  // cache and memory controls
  a_cache_off_probe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctl.cache_off |-> (!cache_probe_en && dma_to_dram)) else $error("cache not ignored");
  a_cache_on_probe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctl.cache_off |-> (cache_probe_en && !dma_to_dram)) else $error("cache ignored while on");
  a_jumper_16mb: assert property (@(posedge sys_clk) disable iff (!rst_n)
    simm_16mb == !sys_config_n[1]) else $error("module size flag bad");
  a_nowrap_low_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctl.wrap_read |-> !first_half_high) else $error("wrap off not low first");
  a_wrap_half: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctl.wrap_read |-> first_half_high == cpu_addr[4]) else $error("wrap on not requested half");

  // slip counter: loads on each read cas, then steps down once per board cycle
  a_slip_zero_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((fill_start || fill_second_cas) && ctl.cas_slip == 2'h0 && !ctl.cache_off) |=> !slip_busy)
    else $error("slip without setting");
  a_slip_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fill_start || fill_second_cas) |=> cas_slip_left == $past(ctl.cas_slip)) else $error("slip not loaded");
  a_slip_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!(fill_start || fill_second_cas) && slip_busy && slip_cnt == 8'h00)
    |=> cas_slip_left == $past(cas_slip_left) - 2'h1) else $error("slip did not step");
  a_slip_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cas_slip_left <= slip_max) else $error("slip count out of range");
endmodule
`default_nettype wire

// *** tb/rom_socket_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rom_socket_model (
  input wire logic sys_clk,
  input wire logic [31:0] io_addr,
  input wire logic rom_socket_zero_en_n,
  input wire logic rom_socket_one_en_n,
  output logic [7:0] io_data
);
  logic [7:0] idle_pat = 8'h5a;
  // a released bus keeps changing, so a stale byte can never pass for a fresh one
  always_ff @(posedge sys_clk) begin
    idle_pat <= ~idle_pat;
  end
  // each socket returns its own address-derived byte; both enabled means contention
  always_comb begin
    if (!rom_socket_zero_en_n && rom_socket_one_en_n) begin
      io_data = io_addr[9:2];
    end else if (!rom_socket_one_en_n && rom_socket_zero_en_n) begin
      io_data = ~io_addr[9:2];
    end else begin
      io_data = idle_pat;
    end
  end
endmodule
`default_nettype wire

// *** tb/board_system_register_rom_window_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module board_system_register_rom_window_test;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic zone_select = 1'b0, reg_write = 1'b0, reg_read = 1'b0, fill_start = 1'b0, fill_second_cas = 1'b0;
  logic rom_size_1mb = 1'b0, rom_select_one = 1'b0;
  logic [33:0] cpu_addr = 34'h0;
  logic [31:0] wr_data = 32'h0;
  logic [1:0] simm_presence_detect = 2'h0;
  logic [3:0] sys_config_n = 4'hf;
  logic [31:0] rd_data, io_addr, w;
  logic [7:0] io_data, romb;
  logic [33:0] a;
  logic zone_claim_n, rom_top_addr, rom_socket_zero_en_n, rom_socket_one_en_n, slip_busy;
  logic first_half_high, cache_probe_en, dma_to_dram, simm_16mb;
  logic [3:0] analyzer_out;
  logic [1:0] cas_slip_left, cache_size;
  logic [2:0] mem_type;
  logic [31:0] wvals [3] = '{32'hffffffff, 32'h3e5aa5ff, 32'h000000ff};
  int n_errors = 0;
  int compares = 0;
  int busy;

  board_system_register_rom_window DUT (.sys_clk, .resetn, .zone_select, .reg_write, .reg_read, .cpu_addr,
    .wr_data, .rd_data, .zone_claim_n, .io_addr, .io_data, .rom_size_1mb, .rom_select_one, .rom_top_addr,
    .rom_socket_zero_en_n, .rom_socket_one_en_n, .simm_presence_detect, .sys_config_n, .analyzer_out,
    .fill_start, .fill_second_cas, .cas_slip_left, .slip_busy, .first_half_high, .cache_probe_en,
    .dma_to_dram, .cache_size, .mem_type, .simm_16mb);
  rom_socket_model rom (.sys_clk, .io_addr, .rom_socket_zero_en_n, .rom_socket_one_en_n, .io_data);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one strobe cycle per access; the claim must already be low while the strobe stands
  task automatic wr(input logic [31:0] d);
    @(posedge sys_clk);
    #2 {zone_select, reg_write, wr_data} = {2'h3, d};
    #1 check(32'(zone_claim_n), 32'h0);
    @(posedge sys_clk);
    #2 {zone_select, reg_write} = 2'h0;
  endtask

  task automatic rd(input logic [33:0] ad, input logic [31:0] exp);
    @(posedge sys_clk);
    #2 {zone_select, reg_read, cpu_addr} = {2'h3, ad};
    #1 check(32'(zone_claim_n), 32'h0);
    check(32'({rom_socket_zero_en_n, rom_socket_one_en_n}), rom_select_one ? 32'h2 : 32'h1);
    @(posedge sys_clk);
    #2 {zone_select, reg_read} = 2'h0;
    check(rd_data, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    #2 resetn = 1'b1;
    repeat (3) @(posedge sys_clk);
    #2 check(32'(analyzer_out), 32'h0);
    check(rd_data, 32'h0);
    // idle bus: no claim and both sockets off
    check(32'({zone_claim_n, rom_socket_zero_en_n, rom_socket_one_en_n}), 32'h7);
    // write patterns, then read back with varying jumpers and socket choice
    for (int i = 0; i < 3; i++) begin
      w = wvals[i];
      sys_config_n = 4'h9 ^ 4'(i);
      simm_presence_detect = 2'(i + 1);
      rom_select_one = i[0];
      rom_size_1mb = i[0];
      wr(w);
      check(32'(analyzer_out), 32'(w[29:26]));
      check(32'(cache_size), 32'(w[18:17]));
      check(32'(mem_type), 32'(w[24:22]));
      check(32'({cache_probe_en, dma_to_dram}), 32'({!w[25], w[25]}));
      check(32'(simm_16mb), 32'(!sys_config_n[1]));
      // rom reads keep address bit 29 and bits 8:0 at zero
      a = {5'h0, 20'(i * 20'h3579b + 20'h12345), 9'h0};
      romb = rom_select_one ? ~a[16:9] : a[16:9];
      rd(a, {sys_config_n, simm_presence_detect, w[25:8], romb});
      check(io_addr, {w[16:8], a[29:9], 2'h0});
      check(32'(rom_top_addr), 32'(rom_size_1mb ? a[28] : 1'b1));
    end
    // wrap bit against address bit 4; software keeps the processor side in step
    for (int j = 0; j < 4; j++) begin
      wr({10'h0, j[1], 21'h0});
      cpu_addr = {29'h0, j[0], 4'h0};
      #1 check(32'(first_half_high), 32'(j[1] & j[0]));
    end
    // every slip code, on both read cas strobes; the write itself must not start a slip
    for (int n = 0; n < 4; n++) begin
      wr({11'h0, 2'(n), 19'h0});
      check(32'(slip_busy), 32'h0);
      for (int s = 0; s < 2; s++) begin
        @(posedge sys_clk);
        #2 {fill_second_cas, fill_start} = s[0] ? 2'h2 : 2'h1;
        @(posedge sys_clk);
        #2 {fill_second_cas, fill_start} = 2'h0;
        check(32'(cas_slip_left), 32'(n));
        busy = 0;
        for (int k = 0; k < 20; k++) begin
          busy += int'(slip_busy);
          @(posedge sys_clk);
          #2;
        end
        check(32'(busy), 32'(2 * n));
      end
    end
    // mid-run reset: outputs clear at once, control fields read back as zero afterwards
    @(posedge sys_clk);
    #2 resetn = 1'b0;
    #1 check(rd_data, 32'h0);
    check(32'({cache_size, mem_type, analyzer_out}), 32'h0);
    @(posedge sys_clk);
    #2 resetn = 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(a, {sys_config_n, simm_presence_detect, 18'h0, a[16:9]});
    results();
  end
endmodule
`default_nettype wire
